// ==== drc_ctrl.sv ====
// Host controller sequencing the strobes of a 64K x 1 dynamic RAM
module drc_ctrl #(
   parameter int INTERVAL_CYC = drc_pkg::REF_INTERVAL_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Access requests
   input wire logic reqValid,
   input wire drc_pkg::drc_op_t reqOp,
   input wire logic [drc_pkg::ADDR_W-1:0] reqAddr,
   input wire logic reqData,
   input wire logic reqKeepRow,
   output logic reqReady,
   // Read answers
   output logic rspValid,
   output logic rspData,
   // Refresh control and status
   input wire logic refAuto,
   input wire logic sleepReq,
   output logic selfActive,
   // Memory pins
   output logic rasN,
   output logic casN,
   output logic weN,
   output logic refN,
   output logic [drc_pkg::HALF_W-1:0] memAddr,
   output logic memD,
   input wire logic memQ
);
   import drc_pkg::*;

   typedef struct packed {
      drc_state_t state;
      logic [CNT_W-1:0] cnt;
      drc_op_t op;
      logic [ADDR_W-1:0] addr;
      logic data;
      logic keep;
      logic refOnly;
      logic pendOpen;
      logic [REF_ROW_W-1:0] refRow;
      logic [2:0] qSync;
      logic qFilt;
      logic rasN;
      logic casN;
      logic weN;
      logic refN;
      logic [HALF_W-1:0] memAddr;
      logic memD;
      logic reqReady;
      logic rspValid;
      logic rspData;
      logic refAck;
      logic selfActive;
   } drc_ctrl_state_t;

   localparam drc_ctrl_state_t RESET_STATE = '{
      state: DRC_ST_IDLE, cnt: '0, op: DRC_OP_READ, addr: '0, data: 1'h0, keep: 1'h0,
      refOnly: 1'h0, pendOpen: 1'h0, refRow: '0, qSync: 3'h0, qFilt: 1'h0,
      rasN: 1'h1, casN: 1'h1, weN: 1'h1, refN: 1'h1, memAddr: '0, memD: 1'h0,
      reqReady: 1'h0, rspValid: 1'h0, rspData: 1'h0, refAck: 1'h0, selfActive: 1'h0};

   drc_ctrl_state_t r_reg;
   drc_ctrl_state_t r_next;
   drc_refresh_if rf ();

   logic [HALF_W-1:0] reqRow;
   logic [HALF_W-1:0] reqCol;
   logic [HALF_W-1:0] curRow;
   logic [HALF_W-1:0] curCol;
   logic refDue;
   logic mayAccept;

   assign reqRow = reqAddr[ROW_LSB +: HALF_W];
   assign reqCol = reqAddr[COL_LSB +: HALF_W];
   assign curRow = r_reg.addr[ROW_LSB +: HALF_W];
   assign curCol = r_reg.addr[COL_LSB +: HALF_W];
   assign refDue = rf.pending && !r_reg.refAck;
   assign mayAccept = reqValid && r_reg.reqReady;
   assign rf.ack = r_reg.refAck;

   drc_refresh_timer #(
      .INTERVAL_CYC(INTERVAL_CYC)
   ) u_timer (
      .clk(clk),
      .resetn(resetn),
      .rf(rf)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer

   always_comb begin
      r_next = r_reg;
      r_next.rspValid = 1'h0;
      r_next.refAck = 1'h0;
      // Data pin crosses in through three flops; second and third must agree
      r_next.qSync = {r_reg.qSync[1:0], memQ};
      if (r_reg.qSync[1] == r_reg.qSync[2]) begin
         r_next.qFilt = r_reg.qSync[2];
      end
      case (r_reg.state)
         DRC_ST_IDLE: begin
            // Standby: both row strobe and refresh pin high
            r_next.reqReady = !rf.pending && !sleepReq;
            if (mayAccept) begin
               r_next.op = reqOp;
               r_next.addr = reqAddr;
               r_next.data = reqData;
               r_next.keep = reqKeepRow;
               r_next.refOnly = 1'h0;
               r_next.memAddr = reqRow;
               r_next.reqReady = 1'h0;
               r_next.state = DRC_ST_RSET;
            end else if (refDue) begin
               r_next.refAck = 1'h1;
               r_next.reqReady = 1'h0;
               if (refAuto) begin
                  // Device supplies its own row address; row strobe stays high
                  r_next.refN = 1'h0;
                  r_next.cnt = REF_CYC - 1'b1;
                  r_next.state = DRC_ST_REFA;
               end else begin
                  r_next.refOnly = 1'h1;
                  r_next.memAddr = {1'h0, r_reg.refRow};
                  r_next.state = DRC_ST_RSET;
               end
            end else if (sleepReq) begin
               r_next.refN = 1'h0;
               r_next.reqReady = 1'h0;
               r_next.selfActive = 1'h1;
               r_next.state = DRC_ST_SELF;
            end
         end
         DRC_ST_RSET: begin
            r_next.rasN = 1'h0;
            r_next.cnt = (r_reg.refOnly ? REF_CYC : ROW_HOLD_CYC) - 1'b1;
            r_next.state = DRC_ST_RAS;
         end
         DRC_ST_RAS: begin
            if (r_reg.cnt != '0) begin
               r_next.cnt = r_reg.cnt - 1'b1;
            end else if (r_reg.refOnly) begin
               // Column strobe never falls, so the output stays open
               r_next.rasN = 1'h1;
               r_next.refRow = r_reg.refRow + 1'b1;
               r_next.cnt = PRE_CYC - 1'b1;
               r_next.state = DRC_ST_PRE;
            end else begin
               r_next.memAddr = curCol;
               r_next.memD = r_reg.data;
               r_next.weN = (r_reg.op == DRC_OP_EARLY_WRITE) ? 1'h0 : 1'h1;
               r_next.state = DRC_ST_COLS;
            end
         end
         DRC_ST_COLS: begin
            // Column strobe falls after the row hold, inside the gated window
            r_next.casN = 1'h0;
            r_next.cnt = CAS_CYC - 1'b1;
            r_next.state = DRC_ST_CAS;
         end
         DRC_ST_CAS: begin
            if (r_reg.cnt != '0) begin
               r_next.cnt = r_reg.cnt - 1'b1;
            end else begin
               // Sampled while the column strobe is still low, so the bit is driven
               if (r_reg.op == DRC_OP_READ || r_reg.op == DRC_OP_RMW) begin
                  r_next.rspData = r_reg.qFilt;
                  r_next.rspValid = 1'h1;
               end
               if (r_reg.op == DRC_OP_RMW || r_reg.op == DRC_OP_DELAYED_WRITE) begin
                  r_next.memD = r_reg.data;
                  r_next.weN = 1'h0;
                  r_next.cnt = WE_CYC - 1'b1;
                  r_next.state = DRC_ST_WEL;
               end else begin
                  r_next.casN = 1'h1;
                  r_next.weN = 1'h1;
                  if (r_reg.keep) begin
                     r_next.reqReady = !rf.pending && !sleepReq;
                     r_next.state = DRC_ST_PAGE;
                  end else begin
                     r_next.rasN = 1'h1;
                     r_next.cnt = PRE_CYC - 1'b1;
                     r_next.state = DRC_ST_PRE;
                  end
               end
            end
         end
         DRC_ST_WEL: begin
            if (r_reg.cnt != '0) begin
               r_next.cnt = r_reg.cnt - 1'b1;
            end else begin
               r_next.casN = 1'h1;
               r_next.weN = 1'h1;
               if (r_reg.keep) begin
                  r_next.reqReady = !rf.pending && !sleepReq;
                  r_next.state = DRC_ST_PAGE;
               end else begin
                  r_next.rasN = 1'h1;
                  r_next.cnt = PRE_CYC - 1'b1;
                  r_next.state = DRC_ST_PRE;
               end
            end
         end
         DRC_ST_PAGE: begin
            // Row held open; further accesses to the same row only strobe a new column
            r_next.reqReady = !rf.pending && !sleepReq;
            if (mayAccept && reqRow == curRow) begin
               r_next.op = reqOp;
               r_next.addr = reqAddr;
               r_next.data = reqData;
               r_next.keep = reqKeepRow;
               r_next.memAddr = reqCol;
               r_next.memD = reqData;
               r_next.weN = (reqOp == DRC_OP_EARLY_WRITE) ? 1'h0 : 1'h1;
               r_next.reqReady = 1'h0;
               r_next.state = DRC_ST_COLS;
            end else if (mayAccept || rf.pending || sleepReq) begin
               // Other row, refresh or sleep: close the row first
               if (mayAccept) begin
                  r_next.op = reqOp;
                  r_next.addr = reqAddr;
                  r_next.data = reqData;
                  r_next.keep = reqKeepRow;
                  r_next.pendOpen = 1'h1;
               end
               r_next.reqReady = 1'h0;
               r_next.rasN = 1'h1;
               r_next.cnt = PRE_CYC - 1'b1;
               r_next.state = DRC_ST_PRE;
            end
         end
         DRC_ST_PRE: begin
            if (r_reg.cnt != '0) begin
               r_next.cnt = r_reg.cnt - 1'b1;
            end else if (r_reg.pendOpen) begin
               r_next.pendOpen = 1'h0;
               r_next.refOnly = 1'h0;
               r_next.memAddr = curRow;
               r_next.state = DRC_ST_RSET;
            end else begin
               r_next.reqReady = !rf.pending && !sleepReq;
               r_next.state = DRC_ST_IDLE;
            end
         end
         DRC_ST_REFA: begin
            if (r_reg.cnt != '0) begin
               r_next.cnt = r_reg.cnt - 1'b1;
            end else begin
               r_next.refN = 1'h1;
               r_next.cnt = PRE_CYC - 1'b1;
               r_next.state = DRC_ST_PRE;
            end
         end
         DRC_ST_SELF: begin
            // Timer slots are absorbed by the device's own refresh
            if (rf.pending && !r_reg.refAck) begin
               r_next.refAck = 1'h1;
            end
            if (!sleepReq) begin
               r_next.refN = 1'h1;
               r_next.selfActive = 1'h0;
               r_next.cnt = PRE_CYC - 1'b1;
               r_next.state = DRC_ST_PRE;
            end
         end
         default: begin
            r_next = RESET_STATE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         r_reg <= RESET_STATE;
      end else begin
         r_reg <= r_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign reqReady = r_reg.reqReady;
   assign rspValid = r_reg.rspValid;
   assign rspData = r_reg.rspData;
   assign selfActive = r_reg.selfActive;
   assign rasN = r_reg.rasN;
   assign casN = r_reg.casN;
   assign weN = r_reg.weN;
   assign refN = r_reg.refN;
   assign memAddr = r_reg.memAddr;
   assign memD = r_reg.memD;
endmodule

// ==== drc_pkg.sv ====
// Shared constants and types for the strobe-multiplexed DRAM host controller
package drc_pkg;
   localparam int ADDR_W = 16;
   localparam int HALF_W = 8;
   localparam int ROW_LSB = 8;
   localparam int COL_LSB = 0;
   localparam int CNT_W = 8;
   localparam int REF_ROW_W = 7;
   localparam int REF_ROWS = 128;

   // Clock rate and timing figures in nanoseconds
   localparam int CLK_MHZ = 25;
   localparam int ROW_HOLD_NS = 40;
   localparam int CAS_ACCESS_NS = 120;
   localparam int WE_LOW_NS = 80;
   localparam int PRECHARGE_NS = 120;
   localparam int REF_PULSE_NS = 200;
   localparam int REF_WINDOW_NS = 2000000;
   localparam int SYNC_CYC = 4;

   // Least times round up, the refresh spacing (a longest time) rounds down
   localparam logic [CNT_W-1:0] ROW_HOLD_CYC = CNT_W'((ROW_HOLD_NS * CLK_MHZ + 999) / 1000);
   localparam logic [CNT_W-1:0] CAS_CYC = CNT_W'((CAS_ACCESS_NS * CLK_MHZ + 999) / 1000 + SYNC_CYC);
   localparam logic [CNT_W-1:0] WE_CYC = CNT_W'((WE_LOW_NS * CLK_MHZ + 999) / 1000);
   localparam logic [CNT_W-1:0] PRE_CYC = CNT_W'((PRECHARGE_NS * CLK_MHZ + 999) / 1000);
   localparam logic [CNT_W-1:0] REF_CYC = CNT_W'((REF_PULSE_NS * CLK_MHZ + 999) / 1000);
   localparam int REF_INTERVAL_CYC = (REF_WINDOW_NS / REF_ROWS) * CLK_MHZ / 1000;

   typedef enum logic [1:0] {
      DRC_OP_READ = 2'h0,
      DRC_OP_EARLY_WRITE = 2'h1,
      DRC_OP_RMW = 2'h2,
      DRC_OP_DELAYED_WRITE = 2'h3
   } drc_op_t;

   typedef enum logic [3:0] {
      DRC_ST_IDLE = 4'h0,
      DRC_ST_RSET = 4'h1,
      DRC_ST_RAS = 4'h3,
      DRC_ST_COLS = 4'h2,
      DRC_ST_CAS = 4'h6,
      DRC_ST_WEL = 4'h7,
      DRC_ST_PRE = 4'h5,
      DRC_ST_PAGE = 4'h4,
      DRC_ST_REFA = 4'hC,
      DRC_ST_SELF = 4'hD
   } drc_state_t;
endpackage

// ==== drc_refresh_if.sv ====
// Refresh request handshake between the interval timer and the sequencer
interface drc_refresh_if;
   logic pending;
   logic ack;
   modport timer (output pending, input ack);
   modport ctrl (input pending, output ack);
endinterface

// ==== drc_refresh_timer.sv ====
// Refresh interval timer raising a sticky request per row slot
module drc_refresh_timer #(
   parameter int INTERVAL_CYC = drc_pkg::REF_INTERVAL_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Request handshake
   drc_refresh_if.timer rf
);
   import drc_pkg::*;

   localparam int TW = $clog2(INTERVAL_CYC + 1);

   typedef struct packed {
      logic [TW-1:0] cnt;
      logic pending;
   } drc_tmr_state_t;

   drc_tmr_state_t r_reg;
   drc_tmr_state_t r_next;

   assign rf.pending = r_reg.pending;

   always_comb begin
      r_next = r_reg;
      if (rf.ack) begin
         r_next.pending = 1'h0;
      end
      // A new slot set in the same cycle as the ack wins
      if (r_reg.cnt == '0) begin
         r_next.cnt = TW'(INTERVAL_CYC - 1);
         r_next.pending = 1'h1;
      end else begin
         r_next.cnt = r_reg.cnt - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         r_reg <= '{cnt: TW'(INTERVAL_CYC - 1), pending: 1'h0};
      end else begin
         r_reg <= r_next;
      end
   end
endmodule

// ==== drc_dram_model.sv ====
// Behavioural model of the 64K x 1 strobe-multiplexed dynamic RAM
module drc_dram_model (
   // Strobes
   input wire logic rasN,
   input wire logic casN,
   input wire logic weN,
   input wire logic refN,
   // Address and data
   input wire logic [7:0] memAddr,
   input wire logic memD,
   output logic memQ,
   // Observation
   output int refCnt,
   output int rasFalls
);
   timeunit 1ns;
   timeprecision 1ps;
   logic mem [0:65535];
   logic [7:0] row;
   logic [7:0] col;
   logic [6:0] refRow = 7'h00;
   logic early = 1'b0;
   logic casSeen = 1'b0;
   logic outBit = 1'b0;
   initial begin
      refCnt = 0;
      rasFalls = 0;
   end
   always @(negedge rasN) begin
      row = memAddr;
      casSeen = 1'b0;
      rasFalls++;
   end
   // A row cycle without any column strobe counts as a refresh
   always @(posedge rasN) if (!casSeen) refCnt++;
   // Access is timed from the column strobe edge, whatever the row-to-column delay
   always @(negedge casN) begin
      col = memAddr;
      casSeen = 1'b1;
      early = !weN;
      outBit = mem[{row, col}];
      if (!weN) mem[{row, col}] = memD;
   end
   always @(negedge weN) if (!casN && !rasN) mem[{row, col}] = memD;
   always @(negedge refN) if (rasN) begin
      refCnt++;
      refRow++;
   end
   always #14000 if (!refN && rasN) refCnt++;
   // Open output shows the inverse of the last bit, never a stale value
   always_comb memQ = (!casN && !early) ? outBit : !outBit;
endmodule

// ==== drc_ctrl_props.sv ====
// Concurrent checks on the host controller's ports
module drc_ctrl_props #(
   parameter int INTERVAL_CYC = drc_pkg::REF_INTERVAL_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Answers and refresh status
   input wire logic rspValid,
   input wire logic sleepReq,
   input wire logic selfActive,
   // Memory pins
   input wire logic rasN,
   input wire logic casN,
   input wire logic weN,
   input wire logic refN,
   input wire logic [drc_pkg::HALF_W-1:0] memAddr
);
   timeunit 1ns;
   timeprecision 1ps;
   import drc_pkg::*;
   int gapCnt;
   default clocking dcb @(posedge clk); endclocking
   default disable iff (!resetn);
   // Cycles since the last row or refresh-pin activity
   always_ff @(posedge clk) begin
      if (!resetn || !rasN || !refN) gapCnt <= 0;
      else gapCnt <= gapCnt + 1;
   end
   property p_strobeExcl; !(!rasN && !refN); endproperty
   a_strobeExcl: assert property (p_strobeExcl) else $error("row strobe and refresh pin low together");
   property p_rowAddr; $fell(rasN) |-> $stable(memAddr); endproperty
   a_rowAddr: assert property (p_rowAddr) else $error("address moved at row strobe fall");
   property p_colAddr; $fell(casN) |-> $stable(memAddr) && !rasN && !$past(rasN); endproperty
   a_colAddr: assert property (p_colAddr) else $error("column strobe fell without settled row");
   property p_casWindow; $fell(casN) |-> !casN [*7]; endproperty
   a_casWindow: assert property (p_casWindow) else $error("column strobe shorter than access window");
   property p_earlyWrite; $fell(casN) && !weN |-> !$past(weN); endproperty
   a_earlyWrite: assert property (p_earlyWrite) else $error("write strobe not ahead of column strobe");
   property p_earlyQuiet; $fell(casN) && !weN |-> !rspValid [*8]; endproperty
   a_earlyQuiet: assert property (p_earlyQuiet) else $error("answer during early write");
   property p_lateWrite; $fell(weN) && !casN |-> !weN [*2] ##1 (weN && casN); endproperty
   a_lateWrite: assert property (p_lateWrite) else $error("late write strobe length wrong");
   property p_readAnswer; rspValid |-> $past(casN) == 1'b0 && $past(casN, 7) == 1'b0; endproperty
   a_readAnswer: assert property (p_readAnswer) else $error("answer without full column window");
   property p_refreshGap; gapCnt <= INTERVAL_CYC + 30; endproperty
   a_refreshGap: assert property (p_refreshGap) else $error("refresh interval overrun");
   property p_refPulse; $fell(refN) && !sleepReq && !selfActive |-> !refN [*5] ##1 refN; endproperty
   a_refPulse: assert property (p_refPulse) else $error("refresh pin pulse length wrong");
   property p_selfHold; selfActive && $past(selfActive) && sleepReq |-> !refN && rasN; endproperty
   a_selfHold: assert property (p_selfHold) else $error("self refresh pins wrong");
   property p_casInRow; !casN |-> !rasN; endproperty
   a_casInRow: assert property (p_casInRow) else $error("column strobe outside row cycle");
endmodule
bind drc_ctrl drc_ctrl_props #(.INTERVAL_CYC(INTERVAL_CYC)) drc_ctrl_props_inst (
   .clk(clk), .resetn(resetn), .rspValid(rspValid), .sleepReq(sleepReq), .selfActive(selfActive),
   .rasN(rasN), .casN(casN), .weN(weN), .refN(refN), .memAddr(memAddr)
);

// ==== tb.sv ====
// Self-checking bench for the strobe-multiplexed DRAM host controller
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import drc_pkg::*;
   localparam int INTERVAL = 120;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic reqValid = 1'b0;
   drc_op_t reqOp = DRC_OP_READ;
   logic [ADDR_W-1:0] reqAddr = 16'h0000;
   logic reqData = 1'b0, reqKeepRow = 1'b0, refAuto = 1'b0, sleepReq = 1'b0;
   logic reqReady, rspValid, rspData, selfActive, rasN, casN, weN, refN, memD, memQ;
   logic [HALF_W-1:0] memAddr;
   int refCnt, rasFalls;
   int failures = 0;
   int checked = 0;
   int cycles = 0;
   always #20 clk = ~clk;
   drc_ctrl #(.INTERVAL_CYC(INTERVAL)) drc_ctrl_inst (.clk(clk), .resetn(resetn), .reqValid(reqValid),
      .reqOp(reqOp), .reqAddr(reqAddr), .reqData(reqData), .reqKeepRow(reqKeepRow), .reqReady(reqReady),
      .rspValid(rspValid), .rspData(rspData), .refAuto(refAuto), .sleepReq(sleepReq), .selfActive(selfActive),
      .rasN(rasN), .casN(casN), .weN(weN), .refN(refN), .memAddr(memAddr), .memD(memD), .memQ(memQ));
   drc_dram_model drc_dram_model_inst (.rasN(rasN), .casN(casN), .weN(weN), .refN(refN), .memAddr(memAddr),
      .memD(memD), .memQ(memQ), .refCnt(refCnt), .rasFalls(rasFalls));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] expv, input logic [31:0] got);
      checked++;
      if (got !== expv) begin
         failures++;
         $display("[FAIL] %s expected %0h seen %0h", what, expv, got);
      end
   endtask
   task automatic conclude();
      if (failures == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic access(input drc_op_t op, input logic [15:0] a, input logic d, input logic keep, output logic q);
      int n;
      @(posedge clk);
      reqValid <= 1'b1;
      reqOp <= op;
      reqAddr <= a;
      reqData <= d;
      reqKeepRow <= keep;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (reqReady !== 1'b1 && n < 400);
      reqValid <= 1'b0;
      chk("request accepted", 32'h1, 32'(n < 400));
      n = 0;
      while ((op == DRC_OP_READ || op == DRC_OP_RMW) && rspValid !== 1'b1 && n < 100) begin
         @(posedge clk);
         n++;
      end
      q = rspData;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_write_read();
      logic [15:0] addrs [4] = '{16'h0000, 16'hFFFF, 16'h5AA5, 16'h5AA4};
      logic bits [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
      logic q;
      foreach (addrs[i]) access(DRC_OP_EARLY_WRITE, addrs[i], bits[i], 1'b0, q);
      foreach (addrs[i]) begin
         access(DRC_OP_READ, addrs[i], 1'b0, 1'b0, q);
         chk("read back", 32'(bits[i]), 32'(q));
         chk("cell placement", 32'(bits[i]), 32'(drc_dram_model_inst.mem[addrs[i]]));
      end
   endtask
   task automatic t_late_writes();
      logic q;
      access(DRC_OP_RMW, 16'h5AA5, 1'b0, 1'b0, q);
      chk("modify old bit", 32'h1, 32'(q));
      chk("modify new bit", 32'h0, 32'(drc_dram_model_inst.mem[16'h5AA5]));
      access(DRC_OP_DELAYED_WRITE, 16'hA55A, 1'b1, 1'b0, q);
      access(DRC_OP_READ, 16'hA55A, 1'b0, 1'b0, q);
      chk("delayed write bit", 32'h1, 32'(q));
   endtask
   task automatic t_page();
      int r, n;
      logic q;
      refAuto <= 1'b0;
      r = refCnt;
      n = 0;
      while (refCnt == r && n < 400) begin
         @(posedge clk);
         n++;
      end
      r = rasFalls;
      access(DRC_OP_READ, 16'h5A00, 1'b0, 1'b1, q);
      access(DRC_OP_EARLY_WRITE, 16'h5A01, 1'b1, 1'b1, q);
      access(DRC_OP_READ, 16'h5A01, 1'b0, 1'b1, q);
      chk("page read", 32'h1, 32'(q));
      chk("row opens in page", 32'h1, 32'(rasFalls - r));
      // Other row while the page is open: the row closes and reopens
      access(DRC_OP_READ, 16'hFFFF, 1'b0, 1'b0, q);
      chk("page miss read", 32'h1, 32'(q));
      chk("row reopened", 32'h2, 32'(rasFalls - r));
   endtask
   task automatic t_refresh();
      int r;
      for (int m = 0; m < 2; m++) begin
         refAuto <= m[0];
         @(posedge clk);
         r = refCnt;
         repeat (4 * INTERVAL) @(posedge clk);
         chk("refresh count", 32'h1, 32'((refCnt - r) >= 3 && (refCnt - r) <= 5));
      end
   endtask
   task automatic t_sleep();
      int n, bad;
      logic q;
      refAuto <= 1'b0;
      sleepReq <= 1'b1;
      n = 0;
      bad = 0;
      while (selfActive !== 1'b1 && n < 400) begin
         @(posedge clk);
         n++;
      end
      chk("self refresh entered", 32'h1, 32'(selfActive));
      repeat (400) begin
         @(posedge clk);
         if (refN !== 1'b0 || rasN !== 1'b1) bad++;
      end
      chk("self refresh pins", 32'h0, 32'(bad));
      sleepReq <= 1'b0;
      access(DRC_OP_READ, 16'hFFFF, 1'b0, 1'b0, q);
      chk("data after sleep", 32'h1, 32'(q));
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         $display("[FAIL] run length expected below 20000 seen %0d", cycles);
         conclude();
      end
   end
   initial begin
      repeat (2) @(posedge clk);
      chk("pins in reset", 32'hF, 32'({rasN, casN, weN, refN}));
      resetn <= 1'b1;
      repeat (2) @(posedge clk);
      t_write_read();
      t_late_writes();
      t_page();
      t_refresh();
      t_sleep();
      conclude();
   end
endmodule
